// File: src/altmux_pkg.sv
// Function
// - timer C pwm wave drives port three bit 6 in pwm mode
// - uart B request-to-send drives port three bit 6; latch bit resets 0
// - spi clock on port three bit 6: driven as master, received as slave
// - port three bit 5 is timer B external count input in counter mode
// - port three bit 5 is uart A clear-to-send input; resets to 1
// - spi serial data out drives port three bit 5 in both spi modes
// - port three bit 5 feeds quadrature Y phase B when quad enabled
// - port three bit 4 is timer A count input in counter mode; that input resets 0
// - uart A request-to-send drives port three bit 4
// - spi serial data in is received on port three bit 4
// - port three bit 4 feeds quadrature Y phase A when quad enabled
// - port three bit 3 delivers external interrupt B; resets to 1
// - port three bit 2 delivers external interrupt A; resets to 1
// - uart A transmit data drives port three bit 1; resets to 1
// - port three bit 1 feeds quadrature X phase B when quad enabled
// - port three bit 0 carries uart A receive data; resets to 1
// - port three bit 0 feeds quadrature X phase A when quad enabled
// - with and-select set, port one bit 7 outputs AND of (port zero | mask)
// - rf tx/rx indicator on port one bit 7 unless and-select is set, its inverse on bit 6
// - port one bits 4 and 3 feed quadrature Z phases B and A
// - sleep crystal select turns port one bit 4 into crystal input only
// - port one bit 5 is plain read/write gpio, reset value 1
package altmux_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_P3_LATCH = 8'h00;
    localparam logic [7:0] OFS_P1_LATCH = 8'h04;
    localparam logic [7:0] OFS_P3_DIR   = 8'h08;
    localparam logic [7:0] OFS_P1_DIR   = 8'h0c;
    localparam logic [7:0] OFS_FUNC     = 8'h10;
    localparam logic [7:0] OFS_P0_SEL   = 8'h14;
    localparam logic [7:0] OFS_P3_PINS  = 8'h18;
    localparam logic [7:0] OFS_P1_PINS  = 8'h1c;
    // reset values
    localparam logic [7:0] RST_P3_LATCH = 8'h3f;
    localparam logic [7:0] RST_P1_LATCH = 8'hff;
    localparam logic [7:0] RST_DIR      = 8'h00;
    localparam logic [9:0] RST_FUNC     = 10'h000;
    localparam logic [8:0] RST_P0_SEL   = 9'h000;
    localparam logic [7:0] RST_SYNC     = 8'hff;
    // function control bit positions
    localparam int F_PWM_C   = 0;
    localparam int F_UART_B  = 1;
    localparam int F_SPI     = 2;
    localparam int F_SPI_MST = 3;
    localparam int F_CNT_B   = 4;
    localparam int F_UART_A  = 5;
    localparam int F_QUAD    = 6;
    localparam int F_CNT_A   = 7;
    localparam int F_RF_IND  = 8;
    localparam int F_XTAL    = 9;
    localparam int FUNC_W    = 10;
    // and-select position in the port zero select register
    localparam int SEL_AND   = 8;
    localparam int SYNC_LAT  = 3;
endpackage : altmux_pkg

// File: src/pin_sync_if.sv
interface pin_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport core (output raw, input synced);
    modport sync (input raw, output synced);
endinterface : pin_sync_if

// File: src/pin_sync.sv
module pin_sync
    import altmux_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // pins in, synced out
    pin_sync_if.sync  ps
);
    logic [15:0] s1_q, s1_d;
    logic [15:0] s2_q, s2_d;

    // the first stage feeds only the second stage
    genvar i;
    for (i = 0; i < 16; i++) begin : g_bit
        always_comb begin
            s1_d[i] = ps.raw[i];
            s2_d[i] = s1_q[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_q <= {RST_SYNC, RST_SYNC};
            s2_q <= {RST_SYNC, RST_SYNC};
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign ps.synced = s2_q;
endmodule : pin_sync

// File: src/port_alt_function_mux.sv
// The implementer's own choices: the register addresses and the APB slave port.
module port_alt_function_mux
    import altmux_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // package pins
    input  wire logic [7:0]  P3_PIN_IN,
    output logic      [7:0]  P3_PIN_OUT,
    output logic      [7:0]  P3_PIN_OE,
    input  wire logic [7:0]  P1_PIN_IN,
    output logic      [7:0]  P1_PIN_OUT,
    output logic      [7:0]  P1_PIN_OE,
    // peripheral outputs heading for pins
    input  wire logic        TIMER_C_WAVE_OUT,
    input  wire logic        UART_B_REQUEST_TO_SEND,
    input  wire logic        SERIAL_PERIPH_CLOCK_OUT,
    input  wire logic        SERIAL_PERIPH_DATA_OUT,
    input  wire logic        UART_A_REQUEST_TO_SEND,
    input  wire logic        UART_A_TX_DATA,
    input  wire logic        RF_TXRX_INDICATOR,
    input  wire logic [7:0]  PORT_ZERO,
    // pin inputs heading for peripherals
    output logic             SERIAL_PERIPH_CLOCK_IN,
    output logic             SERIAL_PERIPH_DATA_IN,
    output logic             TIMER_B_COUNT_IN,
    output logic             TIMER_A_COUNT_IN,
    output logic             UART_A_CLEAR_TO_SEND,
    output logic             UART_A_RX_DATA,
    output logic             EXT_IRQ_A,
    output logic             EXT_IRQ_B,
    output logic             QUAD_X_PHASE_A,
    output logic             QUAD_X_PHASE_B,
    output logic             QUAD_Y_PHASE_A,
    output logic             QUAD_Y_PHASE_B,
    output logic             QUAD_Z_PHASE_A,
    output logic             QUAD_Z_PHASE_B,
    output logic             SLEEP_CRYSTAL_IN
);
    import altmux_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : hit

    pin_sync_if ps ();
    assign ps.raw = {P1_PIN_IN, P3_PIN_IN};

    pin_sync u_sync (
        .clk    (CLK),
        .resetn (RESETN),
        .ps     (ps)
    );

    logic [7:0] p3s;
    logic [7:0] p1s;
    assign p3s = ps.synced[7:0];
    assign p1s = ps.synced[15:8];

    // ---------------- register file ----------------
    logic [7:0]        p3_lat_q, p3_lat_d;
    logic [7:0]        p1_lat_q, p1_lat_d;
    logic [7:0]        p3_dir_q, p3_dir_d;
    logic [7:0]        p1_dir_q, p1_dir_d;
    logic [FUNC_W-1:0] func_q, func_d;
    logic [8:0]        port_zero_select_reg_q, port_zero_select_reg_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              ready_q, ready_d;
    logic              err_q, err_d;
    logic              acc, wr, mapped;

    always_comb begin
        acc      = PSEL && PENABLE && !ready_q;
        wr       = PSEL && PENABLE && ready_q && PWRITE && !err_q;
        p3_lat_d = p3_lat_q;
        p1_lat_d = p1_lat_q;
        p3_dir_d = p3_dir_q;
        p1_dir_d = p1_dir_q;
        func_d   = func_q;
        port_zero_select_reg_d  = port_zero_select_reg_q;
        rdata_d  = rdata_q;
        mapped   = 1'b1;
        ready_d  = acc;
        if (hit(PADDR, OFS_P3_LATCH)) begin
            rdata_d = {24'h000000, p3_lat_q};
            if (wr) p3_lat_d = PWDATA[7:0];
        end else if (hit(PADDR, OFS_P1_LATCH)) begin
            rdata_d = {24'h000000, p1_lat_q};
            if (wr) p1_lat_d = PWDATA[7:0];
        end else if (hit(PADDR, OFS_P3_DIR)) begin
            rdata_d = {24'h000000, p3_dir_q};
            if (wr) p3_dir_d = PWDATA[7:0];
        end else if (hit(PADDR, OFS_P1_DIR)) begin
            rdata_d = {24'h000000, p1_dir_q};
            if (wr) p1_dir_d = PWDATA[7:0];
        end else if (hit(PADDR, OFS_FUNC)) begin
            rdata_d = {22'h000000, func_q};
            if (wr) func_d = PWDATA[FUNC_W-1:0];
        end else if (hit(PADDR, OFS_P0_SEL)) begin
            rdata_d = {23'h000000, port_zero_select_reg_q};
            if (wr) port_zero_select_reg_d = PWDATA[8:0];
        end else if (hit(PADDR, OFS_P3_PINS)) begin
            rdata_d = {24'h000000, p3s};
        end else if (hit(PADDR, OFS_P1_PINS)) begin
            rdata_d = {24'h000000, p1s};
        end else begin
            rdata_d = 32'h00000000;
            mapped  = 1'b0;
        end
        if (!acc) rdata_d = rdata_q;
        err_d = acc ? !mapped : (ready_q ? 1'b0 : err_q);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p3_lat_q <= RST_P3_LATCH;
            p1_lat_q <= RST_P1_LATCH;
            p3_dir_q <= RST_DIR;
            p1_dir_q <= RST_DIR;
            func_q   <= RST_FUNC;
            port_zero_select_reg_q  <= RST_P0_SEL;
            rdata_q  <= 32'h00000000;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            p3_lat_q <= p3_lat_d;
            p1_lat_q <= p1_lat_d;
            p3_dir_q <= p3_dir_d;
            p1_dir_q <= p1_dir_d;
            func_q   <= func_d;
            port_zero_select_reg_q  <= port_zero_select_reg_d;
            rdata_q  <= rdata_d;
            ready_q  <= ready_d;
            err_q    <= err_d;
        end
    end

    assign PRDATA  = rdata_q;
    assign PREADY  = ready_q;
    // err_q is only ever high in the cycle that ready_q is high
    assign PSLVERR = err_q;

    // ---------------- pin multiplexing ----------------
    logic [7:0] p3o_q, p3o_d, p3e_q, p3e_d;
    logic [7:0] p1o_q, p1o_d, p1e_q, p1e_d;
    logic [14:0] pin_q, pin_d;
    logic        and_v;

    always_comb begin
        p3o_d = p3_lat_q;
        p3e_d = p3_dir_q;
        p1o_d = p1_lat_q;
        p1e_d = p1_dir_q;
        and_v = &(PORT_ZERO | port_zero_select_reg_q[7:0]);
        // bit 6 order: pwm, then uart B, then spi clock
        if (func_q[F_PWM_C]) begin
            p3o_d[6] = TIMER_C_WAVE_OUT;
            p3e_d[6] = 1'b1;
        end else if (func_q[F_UART_B]) begin
            p3o_d[6] = UART_B_REQUEST_TO_SEND;
            p3e_d[6] = 1'b1;
        end else if (func_q[F_SPI]) begin
            p3o_d[6] = SERIAL_PERIPH_CLOCK_OUT;
            p3e_d[6] = func_q[F_SPI_MST];
        end
        // bit 5 inputs never fight the spi data driver
        if (func_q[F_SPI]) begin
            p3o_d[5] = SERIAL_PERIPH_DATA_OUT;
            p3e_d[5] = 1'b1;
        end else if (func_q[F_UART_A] || func_q[F_CNT_B]
                     || func_q[F_QUAD]) begin
            p3e_d[5] = 1'b0;
        end
        if (func_q[F_UART_A]) begin
            p3o_d[4] = UART_A_REQUEST_TO_SEND;
            p3e_d[4] = 1'b1;
            p3o_d[1] = UART_A_TX_DATA;
            p3e_d[1] = 1'b1;
            p3e_d[0] = 1'b0;
        end else begin
            if (func_q[F_SPI] || func_q[F_CNT_A] || func_q[F_QUAD])
                p3e_d[4] = 1'b0;
            if (func_q[F_QUAD]) begin
                p3e_d[1] = 1'b0;
                p3e_d[0] = 1'b0;
            end
        end
        // port one bit 7: and-output, then rf indicator
        if (port_zero_select_reg_q[SEL_AND]) begin
            p1o_d[7] = and_v;
            p1e_d[7] = 1'b1;
        end else if (func_q[F_RF_IND]) begin
            p1o_d[7] = RF_TXRX_INDICATOR;
            p1e_d[7] = 1'b1;
        end
        if (func_q[F_RF_IND]) begin
            p1o_d[6] = !RF_TXRX_INDICATOR;
            p1e_d[6] = 1'b1;
        end
        if (func_q[F_XTAL]) begin
            p1o_d[4] = 1'b0;
            p1e_d[4] = 1'b0;
        end else if (func_q[F_QUAD]) begin
            p1e_d[4] = 1'b0;
        end
        if (func_q[F_QUAD]) p1e_d[3] = 1'b0;
        // idle level 1 for uart and interrupt inputs, 0 for the rest
        pin_d[0]  = func_q[F_SPI] ? p3s[6] : 1'b0;
        pin_d[1]  = func_q[F_SPI] ? p3s[4] : 1'b0;
        pin_d[2]  = func_q[F_CNT_B] ? p3s[5] : 1'b0;
        pin_d[3]  = func_q[F_CNT_A] ? p3s[4] : 1'b0;
        pin_d[4]  = func_q[F_UART_A] ? p3s[5] : 1'b1;
        pin_d[5]  = func_q[F_UART_A] ? p3s[0] : 1'b1;
        pin_d[6]  = p3_dir_q[2] ? 1'b1 : p3s[2];
        pin_d[7]  = p3_dir_q[3] ? 1'b1 : p3s[3];
        pin_d[8]  = func_q[F_QUAD] ? p3s[0] : 1'b0;
        pin_d[9]  = func_q[F_QUAD] ? p3s[1] : 1'b0;
        pin_d[10] = func_q[F_QUAD] ? p3s[4] : 1'b0;
        pin_d[11] = func_q[F_QUAD] ? p3s[5] : 1'b0;
        pin_d[12] = func_q[F_QUAD] ? p1s[3] : 1'b0;
        pin_d[13] = func_q[F_QUAD] && !func_q[F_XTAL] ? p1s[4] : 1'b0;
        // a crystal is no logic level; this only tracks it for the timer
        pin_d[14] = func_q[F_XTAL] ? p1s[4] : 1'b0;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            p3o_q <= RST_P3_LATCH;
            p3e_q <= RST_DIR;
            p1o_q <= RST_P1_LATCH;
            p1e_q <= RST_DIR;
            pin_q <= 15'h00f0;
        end else begin
            p3o_q <= p3o_d;
            p3e_q <= p3e_d;
            p1o_q <= p1o_d;
            p1e_q <= p1e_d;
            pin_q <= pin_d;
        end
    end

    assign P3_PIN_OUT = p3o_q;
    assign P3_PIN_OE  = p3e_q;
    assign P1_PIN_OUT = p1o_q;
    assign P1_PIN_OE  = p1e_q;
    assign SERIAL_PERIPH_CLOCK_IN = pin_q[0];
    assign SERIAL_PERIPH_DATA_IN  = pin_q[1];
    assign TIMER_B_COUNT_IN       = pin_q[2];
    assign TIMER_A_COUNT_IN       = pin_q[3];
    assign UART_A_CLEAR_TO_SEND   = pin_q[4];
    assign UART_A_RX_DATA         = pin_q[5];
    assign EXT_IRQ_A              = pin_q[6];
    assign EXT_IRQ_B              = pin_q[7];
    assign QUAD_X_PHASE_A         = pin_q[8];
    assign QUAD_X_PHASE_B         = pin_q[9];
    assign QUAD_Y_PHASE_A         = pin_q[10];
    assign QUAD_Y_PHASE_B         = pin_q[11];
    assign QUAD_Z_PHASE_A         = pin_q[12];
    assign QUAD_Z_PHASE_B         = pin_q[13];
    assign SLEEP_CRYSTAL_IN       = pin_q[14];

    // ---------------- checks ----------------
    // cycles since reset, so pin history predates no reset
    logic [2:0] age_q;
    always_ff @(posedge CLK) begin
        if (!RESETN) age_q <= 3'h0;
        else if (age_q != 3'h4) age_q <= age_q + 3'h1;
    end
    logic run;
    assign run = age_q == 3'h4;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    AST_PWM: assert property (func_q[F_PWM_C] |=>
        P3_PIN_OE[6] && P3_PIN_OUT[6] == $past(TIMER_C_WAVE_OUT))
        else $error("pwm wave not on port three bit 6");
    AST_RTS_B: assert property
        (!func_q[F_PWM_C] && func_q[F_UART_B] |=>
         P3_PIN_OUT[6] == $past(UART_B_REQUEST_TO_SEND))
        else $error("uart B rts not on port three bit 6");
    AST_SPI_CLK: assert property
        (func_q[F_SPI] && !func_q[F_PWM_C] && !func_q[F_UART_B] |=>
         P3_PIN_OE[6] == $past(func_q[F_SPI_MST]))
        else $error("spi clock direction wrong");
    AST_CNT_B: assert property (run && func_q[F_CNT_B] |=>
        TIMER_B_COUNT_IN == $past(P3_PIN_IN[5], 3))
        else $error("timer B count input not from bit 5");
    AST_SPI_DO: assert property (func_q[F_SPI] |=>
        P3_PIN_OE[5] && P3_PIN_OUT[5] == $past(SERIAL_PERIPH_DATA_OUT))
        else $error("spi data out not on bit 5");
    AST_QUAD_Y: assert property (run && func_q[F_QUAD] |=>
        QUAD_Y_PHASE_A == $past(P3_PIN_IN[4], 3) && !P3_PIN_OE[4]
        || $past(func_q[F_UART_A]))
        else $error("quad Y phase A wrong");
    AST_TX_A: assert property (func_q[F_UART_A] |=>
        P3_PIN_OE[1] && P3_PIN_OUT[1] == $past(UART_A_TX_DATA))
        else $error("uart A tx not on bit 1");
    AST_AND: assert property (port_zero_select_reg_q[SEL_AND] |=>
        P1_PIN_OUT[7] == &($past(PORT_ZERO) | $past(port_zero_select_reg_q[7:0])))
        else $error("masked and output wrong");
    AST_RF_INV: assert property
        (func_q[F_RF_IND] && !port_zero_select_reg_q[SEL_AND] |=>
         P1_PIN_OUT[6] == !P1_PIN_OUT[7])
        else $error("rf indicator pair not inverse");
    AST_XTAL: assert property (func_q[F_XTAL] |=>
        !P1_PIN_OE[4] && !QUAD_Z_PHASE_B)
        else $error("crystal pin still used as io");
    AST_GPIO5: assert property (1'b1 |=>
        P1_PIN_OUT[5] == $past(p1_lat_q[5])
        && P1_PIN_OE[5] == $past(p1_dir_q[5]))
        else $error("port one bit 5 not plain gpio");
    AST_APB: assert property (PSEL && PENABLE && !PREADY |=>
        PREADY ##1 !PREADY)
        else $error("apb answer not one cycle");
    AST_RTS_A: assert property (func_q[F_UART_A] |=>
        P3_PIN_OE[4] && P3_PIN_OUT[4] == $past(UART_A_REQUEST_TO_SEND))
        else $error("uart A rts not on bit 4");
    AST_SPI_DI: assert property (run && func_q[F_SPI] |=>
        SERIAL_PERIPH_DATA_IN == $past(P3_PIN_IN[4], 3))
        else $error("spi data in not from bit 4");
    AST_CNT_A: assert property (run && func_q[F_CNT_A] |=>
        TIMER_A_COUNT_IN == $past(P3_PIN_IN[4], 3))
        else $error("timer A count input not from bit 4");
    AST_CTS_A: assert property (run && func_q[F_UART_A] |=>
        UART_A_CLEAR_TO_SEND == $past(P3_PIN_IN[5], 3))
        else $error("uart A cts not from bit 5");
    AST_RX_A: assert property (run && func_q[F_UART_A] |=>
        UART_A_RX_DATA == $past(P3_PIN_IN[0], 3))
        else $error("uart A rx not from bit 0");
    AST_IRQ_A: assert property (run && !p3_dir_q[2] |=>
        EXT_IRQ_A == $past(P3_PIN_IN[2], 3))
        else $error("interrupt A not from bit 2");
    AST_IRQ_B: assert property (run && !p3_dir_q[3] |=>
        EXT_IRQ_B == $past(P3_PIN_IN[3], 3))
        else $error("interrupt B not from bit 3");
    AST_QUAD_X: assert property (run && func_q[F_QUAD] |=>
        QUAD_X_PHASE_A == $past(P3_PIN_IN[0], 3)
        && QUAD_X_PHASE_B == $past(P3_PIN_IN[1], 3))
        else $error("quad X phases wrong");
    AST_QUAD_Z: assert property
        (run && func_q[F_QUAD] && !func_q[F_XTAL] |=>
         QUAD_Z_PHASE_A == $past(P1_PIN_IN[3], 3)
         && QUAD_Z_PHASE_B == $past(P1_PIN_IN[4], 3))
        else $error("quad Z phases wrong");
endmodule : port_alt_function_mux

// File: bench/pin_board.sv
module pin_board (
    // pad drive from the block
    input  wire logic [7:0] three_out,
    input  wire logic [7:0] three_oe,
    input  wire logic [7:0] one_out,
    input  wire logic [7:0] one_oe,
    // levels the board puts on pads the block leaves alone
    input  wire logic [7:0] three_ext,
    input  wire logic [7:0] one_ext,
    // resolved pad levels back to the block
    output logic      [7:0] three_in,
    output logic      [7:0] one_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // the board drives every pad weakly, so a driving block always wins
    always_comb begin
        three_in = (three_oe & three_out) | (~three_oe & three_ext);
        one_in   = (one_oe & one_out) | (~one_oe & one_ext);
    end
endmodule : pin_board

// File: bench/port_alt_function_mux_test.sv
module port_alt_function_mux_test;
    import altmux_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0]  sel;
        logic [31:0] val;
        logic        err;
    } note_t;
    logic        clk = 1'b0;
    logic        resetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr;
    logic [7:0]  thr_o, thr_oe, one_o, one_oe, thr_i, one_i, thr_x, one_x;
    logic [7:0]  zero_v, m;
    logic [6:0]  po;
    logic [14:0] pv;
    logic [46:0] ov;
    note_t       q[$];
    int          n_fail = 0;
    int          n_tests = 0;
    event        chk_ev;

    always #25 clk = ~clk;
    assign ov = {pv, one_oe, one_o, thr_oe, thr_o};

    port_alt_function_mux dut (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr),
        .P3_PIN_IN(thr_i), .P3_PIN_OUT(thr_o), .P3_PIN_OE(thr_oe),
        .P1_PIN_IN(one_i), .P1_PIN_OUT(one_o), .P1_PIN_OE(one_oe),
        .TIMER_C_WAVE_OUT(po[0]), .UART_B_REQUEST_TO_SEND(po[1]),
        .SERIAL_PERIPH_CLOCK_OUT(po[2]), .SERIAL_PERIPH_DATA_OUT(po[3]),
        .UART_A_REQUEST_TO_SEND(po[4]), .UART_A_TX_DATA(po[5]),
        .RF_TXRX_INDICATOR(po[6]), .PORT_ZERO(zero_v),
        .SERIAL_PERIPH_CLOCK_IN(pv[0]), .SERIAL_PERIPH_DATA_IN(pv[1]),
        .TIMER_B_COUNT_IN(pv[2]), .TIMER_A_COUNT_IN(pv[3]),
        .UART_A_CLEAR_TO_SEND(pv[4]), .UART_A_RX_DATA(pv[5]),
        .EXT_IRQ_A(pv[6]), .EXT_IRQ_B(pv[7]), .QUAD_X_PHASE_A(pv[8]),
        .QUAD_X_PHASE_B(pv[9]), .QUAD_Y_PHASE_A(pv[10]),
        .QUAD_Y_PHASE_B(pv[11]), .QUAD_Z_PHASE_A(pv[12]),
        .QUAD_Z_PHASE_B(pv[13]), .SLEEP_CRYSTAL_IN(pv[14])
    );

    pin_board brd (
        .three_out(thr_o), .three_oe(thr_oe), .one_out(one_o),
        .one_oe(one_oe), .three_ext(thr_x), .one_ext(one_x),
        .three_in(thr_i), .one_in(one_i)
    );

    task stop_test;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task cmp(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : cmp

    task take;
        note_t n;
        if (q.size() == 0) begin
            n_fail++;
            $display("ERROR bus answer expected none seen one");
        end else begin
            n = q.pop_front();
            if (n.sel < 8'hfe)
                cmp($sformatf("pin bit %0d", n.sel), {31'b0, ov[n.sel]},
                    n.val);
            else begin
                cmp("pslverr", {31'b0, pslverr}, {31'b0, n.err});
                if (n.sel == 8'hff)
                    cmp("prdata", prdata, n.val);
            end
        end
    endtask : take

    // bus answers are taken at the edge that samples pready high
    always @(posedge clk)
        if (resetn === 1'b1 && psel === 1'b1 && penable === 1'b1
            && pready === 1'b1)
            take();
    always @(chk_ev)
        while (q.size() > 0 && q[0].sel < 8'hfe)
            take();

    task chk(input int i, input logic b);
        q.push_back('{i[7:0], {31'b0, b}, 1'b0});
        -> chk_ev;
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic err);
        int n;
        q.push_back('{(w ? 8'hfe : 8'hff), d, err});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // return mid-cycle so the monitor has taken this answer first
        @(negedge clk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 1'b0);
    endtask : rd

    // new random stimulus, then long enough for the 3-cycle pin path
    task settle;
        @(posedge clk);
        po <= 7'($urandom);
        zero_v <= 8'($urandom);
        thr_x <= 8'($urandom);
        one_x <= 8'($urandom);
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask : settle

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {po, zero_v, thr_x, one_x} = '1;
        void'($urandom(25439));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        r = {8'h00, RST_P1_LATCH, 8'h00, RST_P3_LATCH};
        for (int i = 0; i < 32; i++)
            chk(i, r[i]);
        for (int i = 36; i < 40; i++)
            chk(i, 1'b1);
        rd(OFS_P3_LATCH, 32'h3f);
        rd(OFS_P1_LATCH, 32'hff);
        rd(OFS_FUNC, 32'h0);
        rd(OFS_P0_SEL, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'h5, 1'b1);
        for (int k = 0; k < 2; k++) begin
            r = $urandom;
            wr(OFS_P3_DIR, 32'hff);
            wr(OFS_P1_DIR, 32'hff);
            wr(OFS_P3_LATCH, {24'h0, r[7:0]});
            wr(OFS_P1_LATCH, {24'h0, r[15:8]});
            settle();
            for (int i = 0; i < 8; i++) begin
                chk(i, r[i]);
                chk(16 + i, r[8 + i]);
                chk(8 + i, 1'b1);
                chk(24 + i, 1'b1);
            end
            rd(OFS_P3_PINS, {24'h0, r[7:0]});
            rd(OFS_P1_PINS, {24'h0, r[15:8]});
            wr(OFS_P3_DIR, 32'h0);
            wr(OFS_P1_DIR, 32'h0);
            settle();
            rd(OFS_P3_PINS, {24'h0, thr_x});
            rd(OFS_P1_PINS, {24'h0, one_x});
            chk(38, thr_x[2]);
            chk(39, thr_x[3]);
        end
        for (int k = 0; k < 3; k++) begin
            wr(OFS_FUNC, 1 << F_PWM_C);
            settle();
            chk(6, po[0]);
            chk(14, 1'b1);
            wr(OFS_FUNC, 1 << F_UART_B);
            settle();
            chk(6, po[1]);
            chk(14, 1'b1);
            wr(OFS_FUNC, 32'hf);
            settle();
            chk(6, po[0]);
            wr(OFS_FUNC, (1 << F_SPI) | (1 << F_SPI_MST));
            settle();
            chk(6, po[2]);
            chk(14, 1'b1);
            chk(5, po[3]);
            chk(13, 1'b1);
            chk(33, thr_x[4]);
            wr(OFS_FUNC, 1 << F_SPI);
            settle();
            chk(14, 1'b0);
            chk(32, thr_x[6]);
            chk(5, po[3]);
            chk(33, thr_x[4]);
            wr(OFS_FUNC, (1 << F_UART_A) | (1 << F_CNT_B));
            settle();
            chk(4, po[4]);
            chk(12, 1'b1);
            chk(1, po[5]);
            chk(9, 1'b1);
            chk(36, thr_x[5]);
            chk(37, thr_x[0]);
            chk(34, thr_x[5]);
            wr(OFS_FUNC, 1 << F_CNT_A);
            settle();
            chk(35, thr_x[4]);
            wr(OFS_FUNC, 1 << F_QUAD);
            settle();
            chk(40, thr_x[0]);
            chk(41, thr_x[1]);
            chk(42, thr_x[4]);
            chk(43, thr_x[5]);
            chk(44, one_x[3]);
            chk(45, one_x[4]);
            wr(OFS_FUNC, 1 << F_RF_IND);
            settle();
            chk(23, po[6]);
            chk(22, ~po[6]);
            chk(30, 1'b1);
            wr(OFS_FUNC, (1 << F_XTAL) | (1 << F_QUAD));
            settle();
            chk(46, one_x[4]);
            chk(45, 1'b0);
            chk(28, 1'b0);
            m = k[0] ? 8'hff : 8'($urandom);
            wr(OFS_P0_SEL, {23'h0, 1'b1, m});
            wr(OFS_FUNC, 1 << F_RF_IND);
            settle();
            chk(23, &(zero_v | m));
            chk(31, 1'b1);
            wr(OFS_P0_SEL, 32'h0);
        end
        stop_test();
    end
endmodule : port_alt_function_mux_test
